// File: pss_pkg.sv
/*
 * Shared constants and types for the pipelined synchronous SRAM port.
 * Assumes the widest variant: four nine-bit lanes, each with a parity bit.
 */
package pss_pkg;

    // Array geometry
    localparam int PSS_LANES    = 4;
    localparam int PSS_BYTE_W   = 8;
    localparam int PSS_LANE_W   = 9;
    localparam int PSS_DATA_W   = 32;
    localparam int PSS_WORD_W   = 36;
    localparam int PSS_ADDR_W   = 19;
    localparam int PSS_UPPER_W  = 17;
    localparam int PSS_LSB_W    = 2;
    localparam int PSS_DEPTH    = 524288;

    // Parity lanes carry data; clear for the variant without parity
    localparam logic PSS_PARITY_EN = 1'b1;

    // Enabled edges from the load edge to data capture or data drive
    localparam int PSS_DATA_LAT = 2;

    // Reset values
    localparam logic [PSS_UPPER_W-1:0] PSS_UPPER_RST = 17'h00000;
    localparam logic [PSS_ADDR_W-1:0]  PSS_ADDR_RST  = 19'h00000;
    localparam logic [PSS_LSB_W-1:0]   PSS_LSB_RST   = 2'h0;
    localparam logic [PSS_LANES-1:0]   PSS_LANES_RST = 4'h0;
    localparam logic [PSS_WORD_W-1:0]  PSS_WORD_RST  = 36'h000000000;

    // Burst direction, Gray along idle -> read -> write
    typedef enum logic [1:0] {
        PSS_IDLE = 2'b00,
        PSS_RD   = 2'b01,
        PSS_WR   = 2'b11
    } pss_burst_t;

endpackage

// File: pss_core_if.sv
/*
 * Carrier between the port controller, its burst sequencer and its array.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/1ns
interface pss_core_if;
    import pss_pkg::*;

    // Burst sequencer group
    logic                   load;
    logic                   step;
    logic [PSS_LSB_W-1:0]   load_lsb;
    logic                   linear;
    logic [PSS_LSB_W-1:0]   next_lsb;

    // Array group
    logic                   wr_en;
    logic                   rd_en;
    logic [PSS_ADDR_W-1:0]  addr;
    logic [PSS_LANES-1:0]   lane_wr;
    logic [PSS_WORD_W-1:0]  wdata;
    logic [PSS_WORD_W-1:0]  rdata;

    modport burst_ctl (output load, step, load_lsb, linear, input next_lsb);
    modport burst_gen (input load, step, load_lsb, linear, output next_lsb);
    modport mem_ctl   (output wr_en, rd_en, addr, lane_wr, wdata,
                       input rdata);
    modport mem_arr   (input wr_en, rd_en, addr, lane_wr, wdata,
                       output rdata);
endinterface

// File: pss_burst_seq.sv
/*
 * Two-bit burst sequencer: base position, count, linear or interleaved.
 * Assumes load and step are already qualified by the clock enable.
 */
`timescale 1ns/1ns
module pss_burst_seq (
    input  wire logic     clk_i,
    input  wire logic     rst_b_i,
    pss_core_if.burst_gen bif
);
    import pss_pkg::*;

    logic [PSS_LSB_W-1:0] base;
    logic [PSS_LSB_W-1:0] cnt;
    logic [PSS_LSB_W-1:0] next_cnt;
    logic [PSS_LSB_W-1:0] seq_lsb;

    // Count wraps on its own after the fourth access
    assign next_cnt = cnt + 2'h1; // RULE22
    assign seq_lsb  = bif.linear ? base + next_cnt : base ^ next_cnt; // RULE25
    assign bif.next_lsb = bif.load ? bif.load_lsb : seq_lsb; // RULE2

    // Load presets the base, a step moves one position on
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base <= PSS_LSB_RST;
            cnt  <= PSS_LSB_RST;
        end else if (bif.load) begin
            base <= bif.load_lsb; // RULE2
            cnt  <= PSS_LSB_RST;
        end else if (bif.step) begin
            cnt  <= next_cnt; // RULE7
        end
    end

    a_linear_step: assert property ( // RULE25
        @(posedge clk_i) disable iff (!rst_b_i)
        bif.step && !bif.load && bif.linear
            |-> bif.next_lsb == base + cnt + 2'h1)
        else $error("linear burst step is not base plus count");

    a_interleave_step: assert property ( // RULE25
        @(posedge clk_i) disable iff (!rst_b_i)
        bif.step && !bif.linear
            |-> bif.next_lsb == (base ^ (cnt + 2'h1)))
        else $error("interleaved burst step is not base xor count");

    a_burst_wrap: assert property ( // RULE22
        @(posedge clk_i) disable iff (!rst_b_i)
        (bif.step && !bif.load) [*4] |=> cnt == $past(cnt, 4))
        else $error("burst count did not wrap after four steps");
endmodule

// File: pss_lane_mem.sv
/*
 * Storage array with per-lane write gating and a registered read.
 * Assumes at most one of write or read is asked for in a cycle.
 */
`timescale 1ns/1ns
module pss_lane_mem (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    pss_core_if.mem_arr mif
);
    import pss_pkg::*;

    logic [PSS_WORD_W-1:0] mem [0:PSS_DEPTH-1];
    logic [PSS_WORD_W-1:0] old_word;
    logic [PSS_WORD_W-1:0] merged;
    logic [PSS_WORD_W-1:0] rd_word;

    assign old_word = mem[mif.addr];

    // Each lane keeps its old contents unless its own enable is set
    for (genvar g = 0; g < PSS_LANES; g++) begin : g_lane
        logic par_new;
        assign par_new = PSS_PARITY_EN ? mif.wdata[g*PSS_LANE_W+8]
                                       : 1'b0; // RULE20
        assign merged[g*PSS_LANE_W +: PSS_BYTE_W] = mif.lane_wr[g]
            ? mif.wdata[g*PSS_LANE_W +: PSS_BYTE_W]
            : old_word[g*PSS_LANE_W +: PSS_BYTE_W]; // RULE4
        assign merged[g*PSS_LANE_W+8] = mif.lane_wr[g] ? par_new
            : old_word[g*PSS_LANE_W+8]; // RULE4
    end

    // Array contents have no reset, like the real cells
    always_ff @(posedge clk_i) begin
        if (mif.wr_en) begin
            mem[mif.addr] <= merged;
        end
    end

    // Read word is held until the next read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_word <= PSS_WORD_RST;
        end else if (mif.rd_en) begin
            rd_word <= old_word;
        end
    end
    assign mif.rdata = rd_word;

    a_lane_gate: assert property ( // RULE4
        @(posedge clk_i) disable iff (!rst_b_i)
        mif.wr_en && !mif.lane_wr[0]
            |=> mem[$past(mif.addr)][8:0] == $past(old_word[8:0]))
        else $error("lane a changed although its enable was off");

    // Checks the lane a byte of the stored word, not the merge network that feeds it
    a_data_capture: assert property ( // RULE19
        @(posedge clk_i) disable iff (!rst_b_i)
        mif.wr_en && mif.lane_wr[0]
            |=> mem[$past(mif.addr)][7:0] == $past(mif.wdata[7:0]))
        else $error("lane a write data not stored");
endmodule

// File: pss_sram_port.sv
/*
 * Synchronous control port of a pipelined SRAM with no bus turnaround.
 * Registers address and controls, runs the two-bit burst, types cycles,
 * gates byte lanes and drives read data two enabled edges after a load.
 * Assumes the memory controller drives every synchronous input on clk_i,
 * and treats the output enable and snooze pins as asynchronous levels.
 */
// Contract
// RULE1: Address inputs captured on rising edge.
// RULE2: Low address bits preset the burst counter.
// RULE3: Byte enables travel with the write address.
// RULE4: Each byte enable gates only its lane.
// RULE5: All enables low writes the full word.
// RULE6: Chip selects sampled only on loads.
// RULE7: Advance high steps burst, keeps access type.
// RULE8: Read/write select ignored while advancing.
// RULE9: Advance low loads a fresh address.
// RULE10: Read/write select alone sets cycle type.
// RULE11: Direction changes only through a new load.
// RULE12: Clock gate high freezes all state.
// RULE13: Output enable gates drivers without clock.
// RULE14: Snooze enters standby, array contents kept.
// RULE15: Snooze makes every other input ignored.
// RULE16: Undriven snooze reads as inactive; the port applies no default and relies on a board pull-down.
// RULE17: Order select low linear, high interleaved.
// RULE18: Order select held fixed while operating.
// RULE19: Write data captured on rising edge.
// RULE20: Lane count and parity follow variant.
// RULE21: Write data arrives two cycles after address.
// RULE22: Burst wraps after the fourth access.
// RULE23: Cycle types defined only on loads.
// RULE24: Read data driven two edges after load.
// RULE25: Linear adds count, interleaved XORs count.
// RULE26: Deselect load ends burst, drives nothing.
`timescale 1ns/1ns
module pss_sram_port (
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic                         clock_gate_n_i,
    input  wire logic                         snooze_request_i,
    input  wire logic                         advance_load_n_i,
    input  wire logic                         read_write_sel_i,
    input  wire logic                         chip_sel_n_i,
    input  wire logic                         chip_sel2_n_i,
    input  wire logic                         chip_sel2_i,
    input  wire logic                         linear_order_n_i,
    input  wire logic                         out_drive_en_n_i,
    input  wire logic [pss_pkg::PSS_UPPER_W-1:0] addr_upper_i,
    input  wire logic                         addr_lsb0_i,
    input  wire logic                         addr_lsb1_i,
    input  wire logic                         byte_wr_a_n_i,
    input  wire logic                         byte_wr_b_n_i,
    input  wire logic                         byte_wr_c_n_i,
    input  wire logic                         byte_wr_d_n_i,
    input  wire logic [pss_pkg::PSS_DATA_W-1:0]  lane_data_i,
    input  wire logic [pss_pkg::PSS_LANES-1:0]   lane_parity_i,
    output wire logic [pss_pkg::PSS_DATA_W-1:0]  lane_data_o,
    output wire logic [pss_pkg::PSS_LANES-1:0]   lane_parity_o,
    output wire logic                         lane_data_oe_o,
    output wire logic                         lane_parity_oe_o
);
    import pss_pkg::*;

    pss_core_if core ();

    // Decoded controls
    wire logic                  en;
    wire logic                  load;
    wire logic                  sel;
    wire logic                  live;
    wire logic [PSS_LANES-1:0]  bw_now;
    wire logic [PSS_LSB_W-1:0]  lsb_in;
    wire logic                  drive;

    // Burst direction and held upper address
    pss_burst_t                 st;
    pss_burst_t                 next_st;
    logic [PSS_UPPER_W-1:0]     upper;

    // Stage one: the access named by this edge
    logic                       s1_valid;
    logic                       s1_write;
    logic [PSS_ADDR_W-1:0]      s1_addr;
    logic [PSS_LANES-1:0]       s1_bw;

    // Stage two: one edge later, waiting for data
    logic                       s2_valid;
    logic                       s2_write;
    logic [PSS_ADDR_W-1:0]      s2_addr;
    logic [PSS_LANES-1:0]       s2_bw;

    // Output stage marker
    logic                       rd_valid;

    // Snooze and the clock gate both swallow the edge; snooze is taken
    // straight from its pin so that standby acts without a clock, at the
    // price of needing it clean around edges when it is released
    assign en = !clock_gate_n_i && !snooze_request_i; // RULE12 RULE15
    // A floating snooze pin is pulled low on the board, so a low level
    // here is normal operation and no extra default is applied // RULE16

    assign load   = !advance_load_n_i; // RULE9
    assign sel    = !chip_sel_n_i && !chip_sel2_n_i && chip_sel2_i; // RULE6
    assign live   = st != PSS_IDLE;
    assign lsb_in = {addr_lsb1_i, addr_lsb0_i};
    assign bw_now = {!byte_wr_d_n_i, !byte_wr_c_n_i,
                     !byte_wr_b_n_i, !byte_wr_a_n_i}; // RULE3

    // Burst sequencer hookup; steps only while a burst is live
    assign core.load     = en && load; // RULE2
    assign core.step     = en && !load && live; // RULE7
    assign core.load_lsb = lsb_in;
    assign core.linear   = !linear_order_n_i; // RULE17 RULE18

    pss_burst_seq u_burst (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .bif     (core.burst_gen)
    );

    // Cycle type is decided on loads only; advancing keeps it, so a
    // read burst cannot turn into a write without a new load
    always_comb begin
        next_st = st;
        if (load) begin
            if (!sel) begin
                next_st = PSS_IDLE; // RULE26
            end else if (read_write_sel_i) begin
                next_st = PSS_RD; // RULE10
            end else begin
                next_st = PSS_WR; // RULE10
            end
        end
        case (st)
            PSS_IDLE: ;
            PSS_RD:   ;
            PSS_WR:   ;
            default:  next_st = PSS_IDLE;
        endcase
    end

    // Burst state, advance ignores the read/write select
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st    <= PSS_IDLE;
            upper <= PSS_UPPER_RST;
        end else if (en) begin
            st <= next_st; // RULE8 RULE11 RULE23
            if (load) begin
                upper <= addr_upper_i; // RULE1
            end
        end
    end

    // Stage one takes the loaded address or the next burst position
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_valid <= 1'b0;
            s1_write <= 1'b0;
            s1_addr  <= PSS_ADDR_RST;
            s1_bw    <= PSS_LANES_RST;
        end else if (en) begin
            s1_valid <= load ? sel : live; // RULE26
            s1_write <= load ? !read_write_sel_i : (st == PSS_WR);
            s1_addr  <= load ? {addr_upper_i, core.next_lsb}
                             : {upper, core.next_lsb}; // RULE1 RULE7
            s1_bw    <= bw_now; // RULE3
        end
    end

    // Stage two carries the access one more enabled edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s2_valid <= 1'b0;
            s2_write <= 1'b0;
            s2_addr  <= PSS_ADDR_RST;
            s2_bw    <= PSS_LANES_RST;
        end else if (en) begin
            s2_valid <= s1_valid;
            s2_write <= s1_write;
            s2_addr  <= s1_addr;
            s2_bw    <= s1_bw;
        end
    end

    // Array access on the second enabled edge after the load; write data
    // is sampled from the pins on that same edge
    assign core.wr_en   = en && s2_valid && s2_write; // RULE21 RULE19
    assign core.rd_en   = en && s2_valid && !s2_write; // RULE24
    assign core.addr    = s2_addr;
    assign core.lane_wr = s2_bw; // RULE4 RULE5

    // Lane packing: parity sits above its byte in each nine-bit lane
    for (genvar g = 0; g < PSS_LANES; g++) begin : g_pack
        assign core.wdata[g*PSS_LANE_W +: PSS_BYTE_W] =
            lane_data_i[g*PSS_BYTE_W +: PSS_BYTE_W];
        assign core.wdata[g*PSS_LANE_W+8] = lane_parity_i[g]; // RULE20
        assign lane_data_o[g*PSS_BYTE_W +: PSS_BYTE_W] =
            core.rdata[g*PSS_LANE_W +: PSS_BYTE_W];
        assign lane_parity_o[g] = core.rdata[g*PSS_LANE_W+8];
    end

    pss_lane_mem u_mem (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .mif     (core.mem_arr)
    );

    // Read data stays up for one enabled cycle; a stall stretches it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_valid <= 1'b0;
        end else if (en) begin
            rd_valid <= s2_valid && !s2_write; // RULE24 RULE26
        end
    end

    // Output enable and snooze act on the drivers without the clock
    assign drive = rd_valid && !out_drive_en_n_i
                   && !snooze_request_i; // RULE13 RULE14
    assign lane_data_oe_o   = drive;
    assign lane_parity_oe_o = drive && PSS_PARITY_EN; // RULE20

    a_load_capture: assert property ( // RULE1
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && sel
            |=> s1_valid && s1_addr[PSS_ADDR_W-1:PSS_LSB_W]
                == $past(addr_upper_i))
        else $error("loaded address not captured");

    a_burst_preset: assert property ( // RULE2
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load |=> s1_addr[PSS_LSB_W-1:0] == $past(lsb_in))
        else $error("burst start position differs from low address");

    a_deselect_idle: assert property ( // RULE26
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && !sel ##1 en ##1 en |=> !lane_data_oe_o)
        else $error("data driven for a deselected load");

    a_deselect_stage: assert property ( // RULE6
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && !sel |=> !s1_valid && st == PSS_IDLE)
        else $error("deselected load started an access");

    a_dir_hold: assert property ( // RULE11
        @(posedge clk_i) disable iff (!rst_b_i)
        en && !load |=> $stable(st))
        else $error("access direction changed without a load");

    a_advance_keeps: assert property ( // RULE8
        @(posedge clk_i) disable iff (!rst_b_i)
        en && !load && live
            |=> s1_write == ($past(st) == PSS_WR) && s1_valid)
        else $error("advance changed the access type");

    a_type_select: assert property ( // RULE10
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && sel |=> s1_write == !$past(read_write_sel_i))
        else $error("cycle type does not follow read/write select");

    a_stall_hold: assert property ( // RULE12
        @(posedge clk_i) disable iff (!rst_b_i)
        !en |=> $stable(s1_addr) && $stable(s2_addr)
                && $stable(rd_valid) && $stable(st))
        else $error("state moved on a gated edge");

    a_oe_release: assert property ( // RULE13
        @(posedge clk_i) disable iff (!rst_b_i)
        out_drive_en_n_i || snooze_request_i |-> !lane_data_oe_o)
        else $error("drivers on while disabled");

    a_read_latency: assert property ( // RULE24
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && sel && read_write_sel_i ##1 en ##1 en
            |=> rd_valid)
        else $error("read data not presented two edges after load");

    a_write_latency: assert property ( // RULE21
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && sel && !read_write_sel_i ##1 en ##1 en
            |-> core.wr_en)
        else $error("write not taken two edges after load");

    a_full_write: assert property ( // RULE5
        @(posedge clk_i) disable iff (!rst_b_i)
        en && load && sel && !read_write_sel_i && bw_now == 4'hF
            ##1 en ##1 en |-> core.lane_wr == 4'hF)
        else $error("all enables low did not write every lane");
endmodule

// File: pss_ctl_model.sv
/*
 * Controller-side model of the data lines: write data two enabled edges
 * after the write address, a changing pattern while it has none to give.
 * Assumes the bench calls beat once in each cycle that ends in an enabled edge.
 */
`timescale 1ns/1ns
module pss_ctl_model (
    input  wire logic                      clk_i,
    input  wire logic                      clock_gate_n_i,
    input  wire logic                      snooze_request_i,
    output logic [pss_pkg::PSS_DATA_W-1:0] lane_data_o = '0,
    output logic [pss_pkg::PSS_LANES-1:0]  lane_parity_o = '0
);
    import pss_pkg::*;
    logic [PSS_WORD_W:0]   s0 = '0;
    logic [PSS_WORD_W:0]   s1 = '0;
    logic [PSS_WORD_W:0]   s2 = '0;
    logic [PSS_WORD_W-1:0] junk = 36'hA5A5A5A5A;

    // Queue the beat of this cycle; the top bit marks a write beat
    task automatic beat(input logic wr, input logic [PSS_WORD_W-1:0] w);
        s0 = {wr, w};
    endtask

    // Shift on enabled edges only, so a stall stretches the data window
    always @(posedge clk_i) begin
        if (!clock_gate_n_i && !snooze_request_i) begin
            s2 = s1;
            s1 = s0;
            s0 = '0;
        end
        #1;
        junk = ~junk;
        if (s2[PSS_WORD_W]) begin
            {lane_parity_o, lane_data_o} = s2[PSS_WORD_W-1:0];
        end else begin
            {lane_parity_o, lane_data_o} = junk; // Released lines never idle
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the SRAM control port: a table of pin cycles,
 * then output-enable, snooze and reset cases written out by hand.
 * Assumes a 125 MHz clock and the widest lane variant with parity.
 */
`timescale 1ns/1ns
module tb_top;
    import pss_pkg::*;
    typedef struct packed {
        logic        ld_n;
        logic        rw;
        logic [2:0]  cs;
        logic [18:0] a;
        logic [3:0]  be_n;
        logic [3:0]  tg;
        logic        gate_n;
        logic        mo;
    } pss_tb_row_t;
    typedef struct packed {
        pss_burst_t  t;
        logic [18:0] a;
        logic [3:0]  be_n;
        logic [35:0] w;
    } pss_tb_ent_t;
    localparam pss_tb_row_t DSL = '{0, 1, 3'h0, 0, 4'hF, 0, 0, 0};
    localparam pss_tb_row_t RD10 = '{0, 1, 3'h1, 19'h10, 4'hF, 0, 0, 0};
    localparam pss_tb_row_t ADV = '{1, 1, 3'h1, 19'h10, 4'hF, 0, 0, 0};

    logic        clk_i = 1'h0;
    logic        rst_b_i = 1'h0;
    logic        gate_n = 1'h0;
    logic        snooze_z = 1'hz;
    tri0         snooze_w;
    logic        ld_n = 1'h1;
    logic        rw = 1'h1;
    logic [2:0]  cs = 3'h0;
    logic [18:0] a = '0;
    logic [3:0]  be_n = 4'hF;
    logic        lin_n = 1'h0;
    logic        oe_n = 1'h0;
    logic [31:0] wd;
    logic [3:0]  wp;
    logic [31:0] rd;
    logic [3:0]  rp;
    logic        doe;
    logic        poe;
    int          error_cnt = 0;
    int          n_checks = 0;
    logic [35:0] ref_mem [logic [18:0]];
    pss_burst_t  b_typ = PSS_IDLE;
    logic [18:0] b_base = '0;
    logic [1:0]  b_cnt = '0;
    pss_tb_ent_t p [2] = '{default: '0};
    pss_tb_ent_t cur = '0;
    logic        exp_rd = 1'h0;
    logic [35:0] exp_d = '0;

    // Floating snooze must read as inactive
    assign snooze_w = snooze_z;

    pss_sram_port i_pss_sram_port (
        .clk_i            (clk_i),
        .rst_b_i          (rst_b_i),
        .clock_gate_n_i   (gate_n),
        .snooze_request_i (snooze_w),
        .advance_load_n_i (ld_n),
        .read_write_sel_i (rw),
        .chip_sel_n_i     (cs[2]),
        .chip_sel2_n_i    (cs[1]),
        .chip_sel2_i      (cs[0]),
        .linear_order_n_i (lin_n),
        .out_drive_en_n_i (oe_n),
        .addr_upper_i     (a[18:2]),
        .addr_lsb0_i      (a[0]),
        .addr_lsb1_i      (a[1]),
        .byte_wr_a_n_i    (be_n[0]),
        .byte_wr_b_n_i    (be_n[1]),
        .byte_wr_c_n_i    (be_n[2]),
        .byte_wr_d_n_i    (be_n[3]),
        .lane_data_i      (wd),
        .lane_parity_i    (wp),
        .lane_data_o      (rd),
        .lane_parity_o    (rp),
        .lane_data_oe_o   (doe),
        .lane_parity_oe_o (poe)
    );

    pss_ctl_model i_pss_ctl_model (
        .clk_i            (clk_i),
        .clock_gate_n_i   (gate_n),
        .snooze_request_i (snooze_w),
        .lane_data_o      (wd),
        .lane_parity_o    (wp)
    );

    // Free-running clock, 8 ns period
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Byte enables gate whole lanes, the parity bit included
    function automatic logic [35:0] merge(input logic [35:0] m,
                                          input logic [35:0] w,
                                          input logic [3:0]  bn);
        for (int k = 0; k < 4; k++) begin
            if (!bn[k]) begin
                m[8*k +: 8] = w[8*k +: 8];
                m[32+k] = w[32+k];
            end
        end
        return m;
    endfunction

    // One cycle: judge the edge just past, then drive the next pins.
    // The reference works in issue order, so no turnaround is assumed.
    task automatic step(input pss_tb_row_t r);
        pss_tb_ent_t e;
        logic [1:0]  lsb;
        logic [35:0] w;
        @(posedge clk_i);
        #1;
        if (!gate_n && !snooze_w) begin
            e = p[1];
            p[1] = p[0];
            p[0] = cur;
            if (e.t == PSS_WR) ref_mem[e.a] = merge(ref_mem[e.a], e.w, e.be_n);
            exp_rd = (e.t == PSS_RD);
            if (exp_rd) exp_d = ref_mem[e.a];
        end
        chk(36'({doe, poe}), {34'h0, {2{exp_rd & ~oe_n & ~snooze_w}}});
        if (exp_rd) chk({rp, rd}, exp_d);
        gate_n = r.gate_n;
        ld_n = r.ld_n;
        rw = r.rw;
        cs = r.cs;
        a = r.a;
        be_n = r.be_n;
        lin_n = r.mo;
        w = {9{r.tg}} ^ 36'h98421C63A;
        if (!r.gate_n && !snooze_w) begin
            if (!r.ld_n) begin
                b_typ = (r.cs != 3'h1) ? PSS_IDLE : r.rw ? PSS_RD : PSS_WR;
                b_base = r.a;
                b_cnt = 2'h0;
            end else begin
                b_cnt = b_cnt + 2'h1;
            end
            lsb = r.mo ? b_base[1:0] ^ b_cnt : b_base[1:0] + b_cnt;
            cur = '{b_typ, {b_base[18:2], lsb}, r.be_n, w};
            i_pss_ctl_model.beat(b_typ == PSS_WR, w);
        end
    endtask

    // Ordinary cycles: ld_n, rw, cs, addr, be_n, tag, gate_n, order
    pss_tb_row_t rows [] = '{
        '{0, 0, 3'h1, 19'h10, 4'h0, 4'h1, 0, 0},
        '{0, 0, 3'h1, 19'h11, 4'h0, 4'h2, 0, 0},
        '{0, 1, 3'h1, 19'h10, 4'hF, 4'h0, 0, 0},
        '{0, 0, 3'h1, 19'h11, 4'hA, 4'h3, 0, 0},
        '{0, 1, 3'h1, 19'h11, 4'hF, 4'h0, 0, 0},
        '{0, 0, 3'h1, 19'h21, 4'h0, 4'h4, 0, 0},
        '{1, 1, 3'h0, 19'h00, 4'h0, 4'h5, 0, 0},
        '{1, 1, 3'h0, 19'h00, 4'h0, 4'h5, 1, 0},
        '{1, 1, 3'h0, 19'h00, 4'h0, 4'h6, 0, 0},
        '{1, 0, 3'h0, 19'h00, 4'h0, 4'h7, 0, 0},
        '{1, 0, 3'h0, 19'h00, 4'h0, 4'h8, 0, 0},
        '{0, 1, 3'h1, 19'h23, 4'hF, 4'h0, 0, 0},
        '{1, 0, 3'h0, 19'h00, 4'h0, 4'h0, 0, 0},
        '{1, 0, 3'h0, 19'h00, 4'h0, 4'h0, 0, 0},
        '{0, 1, 3'h5, 19'h22, 4'hF, 4'h0, 0, 0},
        '{1, 1, 3'h1, 19'h22, 4'hF, 4'h0, 0, 0},
        '{0, 1, 3'h3, 19'h22, 4'hF, 4'h0, 0, 0},
        '{0, 1, 3'h0, 19'h22, 4'hF, 4'h0, 0, 0},
        '{0, 1, 3'h1, 19'h22, 4'hF, 4'h0, 0, 0},
        '{0, 0, 3'h1, 19'h22, 4'h5, 4'h9, 0, 0},
        '{0, 1, 3'h1, 19'h22, 4'hF, 4'h0, 0, 0},
        DSL,
        DSL,
        '{0, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1},
        '{0, 1, 3'h1, 19'h21, 4'hF, 4'h0, 0, 1},
        '{1, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1},
        '{1, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1},
        '{1, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1},
        '{0, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1},
        '{0, 1, 3'h0, 19'h00, 4'hF, 4'h0, 0, 1}
    };

    // A hung run still reaches the verdict
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        chk(36'({doe, poe}), 36'h0);
        chk({rp, rd}, 36'h0);
        rst_b_i = 1'h1;
        foreach (rows[i]) step(rows[i]);
        $display("test table done");
        step(RD10);
        repeat (3) step(DSL);
        oe_n = 1'h1;
        #1;
        chk(36'({doe, poe}), 36'h0);
        oe_n = 1'h0;
        #1;
        chk(36'({doe, poe}), 36'h3);
        $display("test output enable done");
        snooze_z = 1'h1;
        #1;
        chk(36'({doe, poe}), 36'h0);
        step('{0, 0, 3'h1, 19'h10, 4'h0, 4'hF, 0, 0});
        step(DSL);
        snooze_z = 1'hz;
        step(RD10);
        repeat (3) step(DSL);
        $display("test snooze done");
        // Leave a live read burst and an advance on the pins, so a reset
        // that failed to clear the direction would show read data later
        step(RD10);
        step(ADV);
        rst_b_i = 1'h0;
        #1;
        chk(36'({doe, poe}), 36'h0);
        chk({rp, rd}, 36'h0);
        p = '{default: '0};
        cur = '0;
        b_typ = PSS_IDLE;
        exp_rd = 1'h0;
        repeat (2) @(posedge clk_i);
        #1;
        rst_b_i = 1'h1;
        step(ADV);
        repeat (4) step(DSL);
        $display("test reset done");
        end_sim();
    end
endmodule
